// ---- design/fifo_irq_cfg_pkg.sv ----
package fifo_irq_cfg_pkg;
	// Register offsets on the serial register port
	localparam logic [6:0] ADDR_DECIM = 7'h45;
	localparam logic [6:0] ADDR_THRESH = 7'h46;
	localparam logic [6:0] ADDR_CONTENT = 7'h47;
	localparam logic [6:0] ADDR_IRQ_EN = 7'h51;
	localparam logic [6:0] ADDR_PIN_OUT = 7'h53;
	localparam logic [6:0] ADDR_PIN_IN = 7'h54;
	localparam logic [6:0] ADDR_EVT_MAP = 7'h56;

	// Reset values
	localparam logic [7:0] RST_DECIM = 8'h00;
	localparam logic [7:0] RST_THRESH = 8'h80;
	localparam logic [7:0] RST_CONTENT = 8'h10;
	localparam logic [7:0] RST_IRQ_EN = 8'h00;
	localparam logic [7:0] RST_PIN_OUT = 8'h00;
	localparam logic [7:0] RST_PIN_IN = 8'h00;
	localparam logic [7:0] RST_EVT_MAP = 8'h00;

	// Writable bits per register, the rest read as zero
	localparam logic [7:0] MASK_DECIM = 8'h0f;
	localparam logic [7:0] MASK_IRQ_EN = 8'h70;
	localparam logic [7:0] MASK_PIN_IN = 8'h30;
	localparam logic [7:0] MASK_EVT_MAP = 8'hee;

	// Decimation register fields
	localparam int DECIM_EXP_LSB = 0;
	localparam int DECIM_EXP_W = 3;
	localparam int DECIM_FILT_BIT = 3;

	// Content register fields
	localparam int CONT_RATE_BIT = 7;
	localparam int CONT_HDR_BIT = 4;
	localparam int CONT_TAG1_BIT = 3;
	localparam int CONT_TAG2_BIT = 2;
	localparam int CONT_TIME_BIT = 1;
	localparam int CONT_HALT_BIT = 0;

	// Interrupt engine enables
	localparam int IRQ_THR_BIT = 6;
	localparam int IRQ_FULL_BIT = 5;
	localparam int IRQ_RDY_BIT = 4;

	// Pin output configuration: pin one at low nibble, pin two at high nibble
	localparam int PIN_TWO_BASE = 4;
	localparam int PIN_ONE_BASE = 0;
	localparam int PO_DRIVE_OFS = 3;
	localparam int PO_OD_OFS = 2;
	localparam int PO_POL_OFS = 1;
	localparam int PO_EDGE_OFS = 0;

	// Pin input enables
	localparam int PIN_IN_TWO_BIT = 5;
	localparam int PIN_IN_ONE_BIT = 4;

	// Event map: pin one in bits 7..5, pin two in bits 3..1
	localparam int MAP_ONE_RDY = 7;
	localparam int MAP_ONE_THR = 6;
	localparam int MAP_ONE_FULL = 5;
	localparam int MAP_TWO_RDY = 3;
	localparam int MAP_TWO_THR = 2;
	localparam int MAP_TWO_FULL = 1;

	// Datapath sizes
	localparam int SAMPLE_W = 48;
	localparam int BYTE_CNT_W = 11;
	localparam int THRESH_SHIFT = 2;
	localparam int SKIP_W = 8;
	localparam int DECIM_CNT_W = 8;
endpackage : fifo_irq_cfg_pkg

// ---- design/irq_pin_ctrl.sv ----
`timescale 1ns/1ps
// One interrupt pin: output shaping and trigger-input detection
module irq_pin_ctrl (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Configuration
	input wire logic drive_enable,
	input wire logic driver_type,
	input wire logic polarity,
	input wire logic trigger_style,
	input wire logic input_enable,
	// Event to signal
	input wire logic event_level,
	// Pin
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe_n,
	// Results
	output logic trigger,
	output logic tag
);
	logic event_prev_r;
	logic asserted_prev_r;
	logic pin_out_r;
	logic pin_oe_n_r;
	logic trigger_r;
	logic tag_r;

	// Edge style gives a one-cycle pulse on each rising event, level style follows it
	wire logic event_shaped = trigger_style ? (event_level & ~event_prev_r) : event_level;
	// Output polarity: active high drives a 1 when asserted
	wire logic out_level = polarity ? event_shaped : ~event_shaped;
	// Open drain only pulls low, so the driver lets go when the level is high
	wire logic out_drive = drive_enable & (~driver_type | ~out_level);
	// Input side is only meaningful while the pin is not driven
	wire logic in_active = input_enable & ~drive_enable;
	wire logic asserted_in = polarity ? pin_in : ~pin_in;
	// Trigger detection honours the edge or level setting
	wire logic trig_nxt = in_active & (trigger_style ? (asserted_in & ~asserted_prev_r) : asserted_in);

	// Pin and detector registers
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			event_prev_r <= 1'b0;
			asserted_prev_r <= 1'b0;
			pin_out_r <= 1'b0;
			pin_oe_n_r <= 1'b1;
			trigger_r <= 1'b0;
			tag_r <= 1'b0;
		end else begin
			event_prev_r <= event_level;
			asserted_prev_r <= in_active & asserted_in;
			pin_out_r <= out_level;
			pin_oe_n_r <= ~out_drive;
			trigger_r <= trig_nxt;
			tag_r <= pin_in;
		end
	end

	assign pin_out = pin_out_r;
	assign pin_oe_n = pin_oe_n_r;
	assign trigger = trigger_r;
	assign tag = tag_r;
endmodule : irq_pin_ctrl

// ---- design/fifo_irq_cfg.sv ----
`timescale 1ns/1ps
// How it works
// - FIFO input decimated by two to the exponent
// - Filter-select bit picks pre-filter or filtered samples
// - Threshold event when count exceeds threshold times four
// - Threshold register full byte, resets to 0x80
// - All sources off means FIFO off, no headers
// - Rate enable stores all three axes or none
// - Header enable adds frame headers; content resets 0x10
// - Tag enables tag frames from pin state
// - Pin polarity ignored for frame tagging
// - Overread returns one sensor-time frame when enabled
// - Halt bit stops FIFO writes when full
// - Engine enables: threshold 6, full 5, ready 4
// - Pin driven only while its drive enable set
// - Driver type push-pull or open drain when driven
// - Polarity sets active level, output or trigger input
// - Trigger style edge or level, for driven pins and trigger inputs
// - Input enables at bits 5 and 4
// - Input mode never affects new-data path
// - Events routed to pins by mapping bits
// - Trigger input honours edge or level setting
module fifo_irq_cfg (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// Sample sources
	input wire logic sample_valid,
	input wire logic [fifo_irq_cfg_pkg::SAMPLE_W-1:0] sample_pre,
	input wire logic [fifo_irq_cfg_pkg::SAMPLE_W-1:0] sample_filt,
	// FIFO storage status and readout
	input wire logic [fifo_irq_cfg_pkg::BYTE_CNT_W-1:0] fifo_byte_count,
	input wire logic fifo_full,
	input wire logic host_overread,
	// Frame write side
	output logic frame_wr,
	output logic [fifo_irq_cfg_pkg::SAMPLE_W-1:0] frame_data,
	output logic frame_has_header,
	output logic [1:0] frame_tag,
	output logic drop_oldest,
	output logic [fifo_irq_cfg_pkg::SKIP_W-1:0] skip_count,
	output logic time_frame_req,
	// Power-mode trigger inputs from the pins
	output logic [1:0] pmu_trigger,
	// Interrupt pins
	input wire logic event_pin_one_in,
	output logic event_pin_one_out,
	output logic event_pin_one_oe_n,
	input wire logic event_pin_two_in,
	output logic event_pin_two_out,
	output logic event_pin_two_oe_n
);
	// Configuration registers
	logic [7:0] fifo_decimation_config_r;
	logic [7:0] fifo_fill_threshold_r;
	logic [7:0] fifo_content_config_r;
	logic [7:0] irq_engine_enable_r;
	logic [7:0] irq_pin_output_config_r;
	logic [7:0] irq_pin_input_config_r;
	logic [7:0] irq_event_map_r;

	// Readback and datapath state
	logic [7:0] reg_rdata_r;
	logic reg_rvalid_r;
	logic [fifo_irq_cfg_pkg::DECIM_CNT_W-1:0] decim_cnt_r;
	logic frame_wr_r;
	logic [fifo_irq_cfg_pkg::SAMPLE_W-1:0] frame_data_r;
	logic frame_has_header_r;
	logic [1:0] frame_tag_r;
	logic drop_oldest_r;
	logic [fifo_irq_cfg_pkg::SKIP_W-1:0] skip_count_r;
	logic [fifo_irq_cfg_pkg::SKIP_W-1:0] skip_count_nxt;
	logic time_frame_req_r;
	logic time_sent_r;
	logic ready_evt_r;
	logic [1:0] pin_tag;
	logic [1:0] pin_trig;
	logic [1:0] pmu_trigger_r;

	// Address decode
	wire logic sel_decim = reg_addr == fifo_irq_cfg_pkg::ADDR_DECIM;
	wire logic sel_thresh = reg_addr == fifo_irq_cfg_pkg::ADDR_THRESH;
	wire logic sel_content = reg_addr == fifo_irq_cfg_pkg::ADDR_CONTENT;
	wire logic sel_irq_en = reg_addr == fifo_irq_cfg_pkg::ADDR_IRQ_EN;
	wire logic sel_pin_out = reg_addr == fifo_irq_cfg_pkg::ADDR_PIN_OUT;
	wire logic sel_pin_in = reg_addr == fifo_irq_cfg_pkg::ADDR_PIN_IN;
	wire logic sel_map = reg_addr == fifo_irq_cfg_pkg::ADDR_EVT_MAP;

	// Read multiplexer; unmapped addresses read as zero
	wire logic [7:0] rd_mux =
		sel_decim ? fifo_decimation_config_r :
		sel_thresh ? fifo_fill_threshold_r :
		sel_content ? fifo_content_config_r :
		sel_irq_en ? irq_engine_enable_r :
		sel_pin_out ? irq_pin_output_config_r :
		sel_pin_in ? irq_pin_input_config_r :
		sel_map ? irq_event_map_r : 8'h00;

	// Register writes; reserved bits are masked so they keep reading zero
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			fifo_decimation_config_r <= fifo_irq_cfg_pkg::RST_DECIM;
			fifo_fill_threshold_r <= fifo_irq_cfg_pkg::RST_THRESH;
			fifo_content_config_r <= fifo_irq_cfg_pkg::RST_CONTENT;
			irq_engine_enable_r <= fifo_irq_cfg_pkg::RST_IRQ_EN;
			irq_pin_output_config_r <= fifo_irq_cfg_pkg::RST_PIN_OUT;
			irq_pin_input_config_r <= fifo_irq_cfg_pkg::RST_PIN_IN;
			irq_event_map_r <= fifo_irq_cfg_pkg::RST_EVT_MAP;
		end else if (reg_wr) begin
			if (sel_decim) begin
				fifo_decimation_config_r <= reg_wdata & fifo_irq_cfg_pkg::MASK_DECIM;
			end
			if (sel_thresh) begin
				fifo_fill_threshold_r <= reg_wdata;
			end
			if (sel_content) begin
				fifo_content_config_r <= reg_wdata;
			end
			if (sel_irq_en) begin
				irq_engine_enable_r <= reg_wdata & fifo_irq_cfg_pkg::MASK_IRQ_EN;
			end
			if (sel_pin_out) begin
				irq_pin_output_config_r <= reg_wdata;
			end
			if (sel_pin_in) begin
				irq_pin_input_config_r <= reg_wdata & fifo_irq_cfg_pkg::MASK_PIN_IN;
			end
			if (sel_map) begin
				irq_event_map_r <= reg_wdata & fifo_irq_cfg_pkg::MASK_EVT_MAP;
			end
		end
	end

	// Read answer one cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reg_rdata_r <= 8'h00;
			reg_rvalid_r <= 1'b0;
		end else begin
			reg_rdata_r <= reg_rd ? rd_mux : reg_rdata_r;
			reg_rvalid_r <= reg_rd;
		end
	end

	// Content fields
	wire logic rate_en = fifo_content_config_r[fifo_irq_cfg_pkg::CONT_RATE_BIT];
	wire logic hdr_en = fifo_content_config_r[fifo_irq_cfg_pkg::CONT_HDR_BIT];
	wire logic tag1_en = fifo_content_config_r[fifo_irq_cfg_pkg::CONT_TAG1_BIT];
	wire logic tag2_en = fifo_content_config_r[fifo_irq_cfg_pkg::CONT_TAG2_BIT];
	wire logic time_en = fifo_content_config_r[fifo_irq_cfg_pkg::CONT_TIME_BIT];
	wire logic halt_en = fifo_content_config_r[fifo_irq_cfg_pkg::CONT_HALT_BIT];

	// Decimation mask: exponent e accepts one sample out of 2^e
	wire logic [fifo_irq_cfg_pkg::DECIM_EXP_W-1:0] decim_exp =
		fifo_decimation_config_r[fifo_irq_cfg_pkg::DECIM_EXP_LSB +: fifo_irq_cfg_pkg::DECIM_EXP_W];
	wire logic [fifo_irq_cfg_pkg::DECIM_CNT_W-1:0] decim_one = {{(fifo_irq_cfg_pkg::DECIM_CNT_W-1){1'b0}}, 1'b1};
	wire logic [fifo_irq_cfg_pkg::DECIM_CNT_W-1:0] decim_mask = (decim_one << decim_exp) - decim_one;
	wire logic decim_hit = (decim_cnt_r & decim_mask) == {fifo_irq_cfg_pkg::DECIM_CNT_W{1'b0}};

	// The new-data path is never gated by the pin input mode
	wire logic sample_take = sample_valid & decim_hit;
	// With every source disabled the FIFO is off: no frame and no header
	wire logic fifo_on = rate_en;
	wire logic want_write = sample_take & fifo_on;
	// Halting on full drops the new sample, otherwise the oldest frame goes
	wire logic blocked = fifo_full & halt_en;
	wire logic do_write = want_write & ~blocked;
	wire logic do_drop = do_write & fifo_full;
	wire logic [fifo_irq_cfg_pkg::SAMPLE_W-1:0] sample_sel =
		fifo_decimation_config_r[fifo_irq_cfg_pkg::DECIM_FILT_BIT] ? sample_filt : sample_pre;

	// Skip counter saturates rather than wrap so software never sees a false small value
	always_comb begin
		skip_count_nxt = skip_count_r;
		if (do_drop && skip_count_r != {fifo_irq_cfg_pkg::SKIP_W{1'b1}}) begin
			skip_count_nxt = skip_count_r + {{(fifo_irq_cfg_pkg::SKIP_W-1){1'b0}}, 1'b1};
		end
	end

	// Decimation counter advances on every incoming sample
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			decim_cnt_r <= {fifo_irq_cfg_pkg::DECIM_CNT_W{1'b0}};
		end else if (sample_valid) begin
			decim_cnt_r <= decim_cnt_r + decim_one;
		end
	end

	// Frame composer
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			frame_wr_r <= 1'b0;
			frame_data_r <= {fifo_irq_cfg_pkg::SAMPLE_W{1'b0}};
			frame_has_header_r <= 1'b0;
			frame_tag_r <= 2'h0;
			drop_oldest_r <= 1'b0;
			skip_count_r <= {fifo_irq_cfg_pkg::SKIP_W{1'b0}};
			ready_evt_r <= 1'b0;
		end else begin
			frame_wr_r <= do_write;
			frame_data_r <= do_write ? sample_sel : frame_data_r;
			frame_has_header_r <= do_write & hdr_en;
			frame_tag_r <= do_write ? {tag2_en & pin_tag[1], tag1_en & pin_tag[0]} : 2'h0;
			drop_oldest_r <= do_drop;
			skip_count_r <= skip_count_nxt;
			ready_evt_r <= sample_take;
		end
	end

	// Overread gives exactly one time frame until the next real frame is written
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			time_frame_req_r <= 1'b0;
			time_sent_r <= 1'b0;
		end else begin
			time_frame_req_r <= host_overread & time_en & ~time_sent_r;
			// An overread in the same cycle as a new frame still counts as sent
			if (host_overread && time_en) begin
				time_sent_r <= 1'b1;
			end else if (do_write) begin
				time_sent_r <= 1'b0;
			end
		end
	end

	// Threshold counts four-byte units; widened so 0xff times four fits
	wire logic [fifo_irq_cfg_pkg::BYTE_CNT_W-1:0] thresh_bytes =
		{{(fifo_irq_cfg_pkg::BYTE_CNT_W-8){1'b0}}, fifo_fill_threshold_r} << fifo_irq_cfg_pkg::THRESH_SHIFT;
	wire logic thr_evt = irq_engine_enable_r[fifo_irq_cfg_pkg::IRQ_THR_BIT] & (fifo_byte_count > thresh_bytes);
	wire logic full_evt = irq_engine_enable_r[fifo_irq_cfg_pkg::IRQ_FULL_BIT] & fifo_full;
	wire logic rdy_evt = irq_engine_enable_r[fifo_irq_cfg_pkg::IRQ_RDY_BIT] & ready_evt_r;

	// Event routing onto the two pins
	wire logic pin_one_evt =
		(irq_event_map_r[fifo_irq_cfg_pkg::MAP_ONE_RDY] & rdy_evt) |
		(irq_event_map_r[fifo_irq_cfg_pkg::MAP_ONE_THR] & thr_evt) |
		(irq_event_map_r[fifo_irq_cfg_pkg::MAP_ONE_FULL] & full_evt);
	wire logic pin_two_evt =
		(irq_event_map_r[fifo_irq_cfg_pkg::MAP_TWO_RDY] & rdy_evt) |
		(irq_event_map_r[fifo_irq_cfg_pkg::MAP_TWO_THR] & thr_evt) |
		(irq_event_map_r[fifo_irq_cfg_pkg::MAP_TWO_FULL] & full_evt);

	// Per-pin configuration slices
	wire logic [1:0] drive_enable = {
		irq_pin_output_config_r[fifo_irq_cfg_pkg::PIN_TWO_BASE + fifo_irq_cfg_pkg::PO_DRIVE_OFS],
		irq_pin_output_config_r[fifo_irq_cfg_pkg::PIN_ONE_BASE + fifo_irq_cfg_pkg::PO_DRIVE_OFS]};
	wire logic [1:0] driver_type = {
		irq_pin_output_config_r[fifo_irq_cfg_pkg::PIN_TWO_BASE + fifo_irq_cfg_pkg::PO_OD_OFS],
		irq_pin_output_config_r[fifo_irq_cfg_pkg::PIN_ONE_BASE + fifo_irq_cfg_pkg::PO_OD_OFS]};
	wire logic [1:0] polarity = {
		irq_pin_output_config_r[fifo_irq_cfg_pkg::PIN_TWO_BASE + fifo_irq_cfg_pkg::PO_POL_OFS],
		irq_pin_output_config_r[fifo_irq_cfg_pkg::PIN_ONE_BASE + fifo_irq_cfg_pkg::PO_POL_OFS]};
	wire logic [1:0] trigger_style = {
		irq_pin_output_config_r[fifo_irq_cfg_pkg::PIN_TWO_BASE + fifo_irq_cfg_pkg::PO_EDGE_OFS],
		irq_pin_output_config_r[fifo_irq_cfg_pkg::PIN_ONE_BASE + fifo_irq_cfg_pkg::PO_EDGE_OFS]};
	wire logic [1:0] input_enable = {
		irq_pin_input_config_r[fifo_irq_cfg_pkg::PIN_IN_TWO_BIT],
		irq_pin_input_config_r[fifo_irq_cfg_pkg::PIN_IN_ONE_BIT]};
	wire logic [1:0] pin_evt = {pin_two_evt, pin_one_evt};
	wire logic [1:0] pin_in = {event_pin_two_in, event_pin_one_in};
	logic [1:0] pin_out;
	logic [1:0] pin_oe_n;

	// One shaper per pin
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_pin
			irq_pin_ctrl u_pin (
				.ref_clk(ref_clk),
				.srst(srst),
				.drive_enable(drive_enable[gi]),
				.driver_type(driver_type[gi]),
				.polarity(polarity[gi]),
				.trigger_style(trigger_style[gi]),
				.input_enable(input_enable[gi]),
				.event_level(pin_evt[gi]),
				.pin_in(pin_in[gi]),
				.pin_out(pin_out[gi]),
				.pin_oe_n(pin_oe_n[gi]),
				.trigger(pin_trig[gi]),
				.tag(pin_tag[gi])
			);
		end
	endgenerate

	// Trigger outputs re-registered so the top drives only from flops
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pmu_trigger_r <= 2'h0;
		end else begin
			pmu_trigger_r <= pin_trig;
		end
	end

	assign reg_rdata = reg_rdata_r;
	assign reg_rvalid = reg_rvalid_r;
	assign frame_wr = frame_wr_r;
	assign frame_data = frame_data_r;
	assign frame_has_header = frame_has_header_r;
	assign frame_tag = frame_tag_r;
	assign drop_oldest = drop_oldest_r;
	assign skip_count = skip_count_r;
	assign time_frame_req = time_frame_req_r;
	assign pmu_trigger = pmu_trigger_r;
	assign event_pin_one_out = pin_out[0];
	assign event_pin_one_oe_n = pin_oe_n[0];
	assign event_pin_two_out = pin_out[1];
	assign event_pin_two_oe_n = pin_oe_n[1];
endmodule : fifo_irq_cfg

// ---- test/fifo_irq_cfg_chk.sv ----
`timescale 1ns/1ps
// Timing relations of the register port and frame outputs
module fifo_irq_cfg_chk (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Register port
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	// Frame side
	input wire logic sample_valid,
	input wire logic fifo_full,
	input wire logic host_overread,
	input wire logic frame_wr,
	input wire logic frame_has_header,
	input wire logic [1:0] frame_tag,
	input wire logic drop_oldest,
	input wire logic [fifo_irq_cfg_pkg::SKIP_W-1:0] skip_count,
	input wire logic time_frame_req
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	// Read answer exactly one cycle after the strobe, data held between reads
	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read answer missing");
	a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("read answer without strobe");
	a_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata))
		else $error("read data moved");
	// Frame qualifiers only ride on a frame caused by a sample
	a_frame_cause: assert property (frame_wr |-> $past(sample_valid))
		else $error("frame without sample");
	a_header_in_frame: assert property (frame_has_header |-> frame_wr)
		else $error("header outside frame");
	a_tag_in_frame: assert property ((frame_tag != 2'b00) |-> frame_wr)
		else $error("tag outside frame");
	// Overwrite on full, and the skip count only moves on a drop
	a_drop_full: assert property (drop_oldest |-> frame_wr && $past(fifo_full))
		else $error("drop without full");
	a_skip_cause: assert property ($changed(skip_count) |-> drop_oldest || $past(drop_oldest))
		else $error("skip count moved alone");
	a_time_cause: assert property (time_frame_req |-> $past(host_overread))
		else $error("time frame without overread");
	// Main scenarios reached
	c_frame: cover property (frame_wr && frame_has_header);
	c_drop: cover property (drop_oldest);
	c_time: cover property (time_frame_req);
endmodule : fifo_irq_cfg_chk

// ---- test/host_model.sv ----
`timescale 1ns/1ps
// Host on the register port: one strobe per access
module host_model (
	// Clock
	input wire logic ref_clk,
	// Answer
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	// Requests
	output logic reg_wr,
	output logic reg_rd,
	output logic [6:0] reg_addr,
	output logic [7:0] reg_wdata
);
	// Idle lines show junk so a stale value never passes
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 7'h2a;
		reg_wdata = 8'h55;
	end
	// Write, plus a spare edge so strobes never touch
	task wr(input logic [6:0] a, input logic [7:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		@(posedge ref_clk);
	endtask : wr
	// Read; a missing answer comes back unknown
	task rd(input logic [6:0] a, output logic [7:0] d);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge ref_clk);
		d = reg_rvalid ? reg_rdata : 8'hxx;
	endtask : rd
endmodule : host_model

// ---- test/test_fifo_irq_cfg.sv ----
`timescale 1ns/1ps
// Bench top: clock, reset, host and scenarios
module test_fifo_irq_cfg;
	logic ref_clk, srst, sample_valid, fifo_full, host_overread, reg_wr, reg_rd, reg_rvalid;
	logic frame_wr, frame_has_header, drop_oldest, time_frame_req, f_wr, f_hdr, f_drop, f_req;
	logic p1_out, p1_oe_n, p2_out, p2_oe_n, p1_ext, p2_ext, p1_pin, p2_pin;
	logic [6:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rd_val;
	logic [fifo_irq_cfg_pkg::SAMPLE_W-1:0] sample_pre, sample_filt, frame_data;
	logic [fifo_irq_cfg_pkg::SKIP_W-1:0] skip_count, skip_before;
	logic [10:0] fifo_byte_count;
	logic [1:0] frame_tag, pmu_trigger, f_tag;
	logic [47:0] n;
	int error_cnt = 0;
	int cmp_count = 0;
	fifo_irq_cfg u_fifo_irq_cfg (.ref_clk(ref_clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.sample_valid(sample_valid), .sample_pre(sample_pre), .sample_filt(sample_filt),
		.fifo_byte_count(fifo_byte_count), .fifo_full(fifo_full), .host_overread(host_overread),
		.frame_wr(frame_wr), .frame_data(frame_data), .frame_has_header(frame_has_header),
		.frame_tag(frame_tag), .drop_oldest(drop_oldest), .skip_count(skip_count),
		.time_frame_req(time_frame_req), .pmu_trigger(pmu_trigger), .event_pin_one_in(p1_pin),
		.event_pin_one_out(p1_out), .event_pin_one_oe_n(p1_oe_n), .event_pin_two_in(p2_pin),
		.event_pin_two_out(p2_out), .event_pin_two_oe_n(p2_oe_n));
	host_model u_host_model (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
	// Clock at 250 MHz
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Wire level: the bench drives whatever the block releases
	assign p1_pin = p1_oe_n ? p1_ext : p1_out;
	assign p2_pin = p2_oe_n ? p2_ext : p2_out;
	task chk(input logic [47:0] seen, input logic [47:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [6:0] a, input logic [7:0] d);
		u_host_model.wr(a, d);
	endtask : wr
	task rchk(input logic [6:0] a, input logic [7:0] e);
		u_host_model.rd(a, rd_val);
		chk(48'(rd_val), 48'(e));
	endtask : rchk
	task settle;
		repeat (4) @(posedge ref_clk);
	endtask : settle
	// One strobe; one-cycle outputs are caught mid-cycle after the taking edge
	task pulse(input logic s, input logic o);
		sample_valid <= s;
		host_overread <= o;
		@(posedge ref_clk);
		sample_valid <= 1'b0;
		host_overread <= 1'b0;
		@(negedge ref_clk);
		f_wr = frame_wr;
		f_hdr = frame_has_header;
		f_tag = frame_tag;
		f_drop = drop_oldest;
		f_req = time_frame_req;
		@(posedge ref_clk);
	endtask : pulse
	task t_regs;
		rchk(7'h45, 8'h00);
		rchk(7'h46, 8'h80);
		rchk(7'h47, 8'h10);
		rchk(7'h51, 8'h00);
		rchk(7'h53, 8'h00);
		rchk(7'h54, 8'h00);
		chk(48'({p1_oe_n, p2_oe_n}), 48'h3);
		wr(7'h45, 8'hff);
		rchk(7'h45, 8'h0f);
		wr(7'h46, 8'h5a);
		rchk(7'h46, 8'h5a);
		wr(7'h51, 8'hff);
		rchk(7'h51, 8'h70);
		wr(7'h54, 8'hff);
		rchk(7'h54, 8'h30);
		wr(7'h50, 8'hff);
		rchk(7'h50, 8'h00);
	endtask : t_regs
	task t_frames;
		p1_ext <= 1'b1;
		wr(7'h45, 8'h08);
		wr(7'h47, 8'h98);
		pulse(1'b1, 1'b0);
		chk(48'({f_wr, f_hdr, f_tag}), 48'hd);
		chk(frame_data, sample_filt);
		wr(7'h53, 8'h02);
		wr(7'h45, 8'h00);
		wr(7'h47, 8'h88);
		pulse(1'b1, 1'b0);
		chk(48'({f_wr, f_hdr, f_tag}), 48'h9);
		chk(frame_data, sample_pre);
		for (int e = 1; e < 4; e++) begin
			wr(7'h45, 8'(e));
			n = '0;
			repeat (16) begin
				pulse(1'b1, 1'b0);
				n = n + 48'(f_wr);
			end
			chk(n, 48'(16 >> e));
		end
		wr(7'h45, 8'h00);
		wr(7'h47, 8'h10);
		pulse(1'b1, 1'b0);
		chk(48'({f_wr, f_hdr}), 48'h0);
	endtask : t_frames
	task t_full;
		wr(7'h45, 8'h00);
		wr(7'h47, 8'h81);
		fifo_full <= 1'b1;
		pulse(1'b1, 1'b0);
		chk(48'(f_wr), 48'h0);
		wr(7'h47, 8'h80);
		skip_before = skip_count;
		pulse(1'b1, 1'b0);
		chk(48'({f_wr, f_drop}), 48'h3);
		settle;
		chk(48'(skip_count), 48'(skip_before + 1'b1));
		fifo_full <= 1'b0;
		pulse(1'b0, 1'b1);
		chk(48'(f_req), 48'h0);
		wr(7'h47, 8'h82);
		pulse(1'b0, 1'b1);
		chk(48'(f_req), 48'h1);
		pulse(1'b0, 1'b1);
		chk(48'(f_req), 48'h0);
	endtask : t_full
	// Threshold boundary on pin one, full event on pin two in push-pull style; open drain only checked released with no event
	task t_pins;
		wr(7'h46, 8'h02);
		wr(7'h51, 8'h40);
		wr(7'h56, 8'h40);
		wr(7'h53, 8'h0a);
		fifo_byte_count <= 11'd8;
		settle;
		chk(48'({p1_oe_n, p1_out}), 48'h0);
		fifo_byte_count <= 11'd9;
		settle;
		chk(48'({p1_oe_n, p1_out}), 48'h1);
		wr(7'h51, 8'h20);
		wr(7'h56, 8'h02);
		wr(7'h53, 8'hc0);
		settle;
		chk(48'(p2_oe_n), 48'h1);
		fifo_full <= 1'b1;
		wr(7'h53, 8'h80);
		settle;
		chk(48'({p2_oe_n, p2_out}), 48'h0);
		wr(7'h53, 8'ha0);
		settle;
		chk(48'({p2_oe_n, p2_out}), 48'h1);
		wr(7'h51, 8'h00);
		settle;
		chk(48'(p2_out), 48'h0);
		wr(7'h51, 8'h20);
		wr(7'h53, 8'hb0);
		settle;
		chk(48'(p2_out), 48'h0);
		wr(7'h53, 8'h00);
		settle;
		chk(48'(p2_oe_n), 48'h1);
		fifo_full <= 1'b0;
		// Sample-ready event on pin one while samples keep arriving
		wr(7'h51, 8'h10);
		wr(7'h56, 8'h80);
		wr(7'h53, 8'h0a);
		sample_valid <= 1'b1;
		settle;
		chk(48'({p1_oe_n, p1_out}), 48'h1);
		sample_valid <= 1'b0;
		settle;
		chk(48'(p1_out), 48'h0);
	endtask : t_pins
	task t_trigger;
		wr(7'h54, 8'h10);
		wr(7'h53, 8'h02);
		settle;
		chk(48'(pmu_trigger[0]), 48'h1);
		wr(7'h53, 8'h00);
		settle;
		chk(48'(pmu_trigger[0]), 48'h0);
		p1_ext <= 1'b0;
		settle;
		chk(48'(pmu_trigger[0]), 48'h1);
		wr(7'h54, 8'h00);
		settle;
		chk(48'(pmu_trigger[0]), 48'h0);
		wr(7'h54, 8'h10);
		wr(7'h53, 8'h03);
		p1_ext <= 1'b1;
		settle;
		chk(48'(pmu_trigger[0]), 48'h0);
		// Pin two as an active-low level trigger, pin one input off
		wr(7'h54, 8'h20);
		p2_ext <= 1'b0;
		settle;
		chk(48'(pmu_trigger), 48'h2);
	endtask : t_trigger
	task wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up
	// Main sequence
	initial begin
		srst = 1'b1;
		sample_valid = 1'b0;
		host_overread = 1'b0;
		fifo_full = 1'b0;
		fifo_byte_count = 11'h000;
		sample_pre = 48'h0123456789ab;
		sample_filt = 48'hba9876543210;
		p1_ext = 1'b0;
		p2_ext = 1'b1;
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		t_regs;
		t_frames;
		t_full;
		t_pins;
		t_trigger;
		wrap_up;
	end
	// Watchdog: the run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		error_cnt++;
		wrap_up;
	end
endmodule : test_fifo_irq_cfg
bind fifo_irq_cfg fifo_irq_cfg_chk u_fifo_irq_cfg_chk (.ref_clk(ref_clk), .srst(srst), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sample_valid(sample_valid), .fifo_full(fifo_full),
	.host_overread(host_overread), .frame_wr(frame_wr), .frame_has_header(frame_has_header),
	.frame_tag(frame_tag), .drop_oldest(drop_oldest), .skip_count(skip_count),
	.time_frame_req(time_frame_req));
